// File: sim/samc_checker.sv
// Checker for the mode controller, watching only the top ports.
// Assumes samc_pkg is compiled first; bound into every samc_top.
`timescale 1ns/1ps
module samc_checker
   import samc_pkg::*;
(
   input wire logic        mclk_i,
   input wire logic        sys_rst_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [31:0] prdata_o,
   input wire logic        dtr_i,
   input wire logic        dtr_drv_i,
   input wire logic        ri_o,
   input wire logic        usb_rwake_o,
   input wire logic        rf_en_o,
   input wire logic        card_en_o,
   input wire logic        gnss_en_o,
   input wire logic        sleep_o,
   input wire logic        serial_en_o,
   input wire logic        net_rx_en_o
);
   logic [15:0] lo_cnt_r;
   logic [15:0] hi_cnt_r;
   // An open DTR pin is pulled up, so it counts as high.
   wire         dtr_hi = dtr_i | ~dtr_drv_i;
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         lo_cnt_r <= 16'h0000;
         hi_cnt_r <= 16'h0000;
      end else begin
         lo_cnt_r <= ri_o ? 16'h0000 : lo_cnt_r + 16'h0001;
         hi_cnt_r <= usb_rwake_o ? hi_cnt_r + 16'h0001 : 16'h0000;
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   ri_width_a: assert property ($rose(ri_o) |-> lo_cnt_r == RI_PULSE_CYC)
      else $error("ring pulse width wrong");
   rwake_width_a: assert property ($fell(usb_rwake_o) |-> hi_cnt_r == RWAKE_PULSE_CYC)
      else $error("remote wakeup pulse width wrong");
   wake_excl_a: assert property (usb_rwake_o |-> ri_o)
      else $error("both wake signals active");
   card_rf_a: assert property (!card_en_o |-> !rf_en_o)
      else $error("card off while radio on");
   gnss_keep_a: assert property (serial_en_o |-> gnss_en_o)
      else $error("positioning off while running");
   rx_sleep_a: assert property (sleep_o && rf_en_o |-> net_rx_en_o)
      else $error("network reception off in sleep");
   sleep_dtr_a: assert property ($rose(sleep_o) |-> $past(dtr_hi, 1) || $past(dtr_hi, 2)
                                 || $past(dtr_hi, 3) || $past(dtr_hi, 4))
      else $error("sleep entered with DTR low");
   pdown_rd_a: assert property (psel_i && penable_i && !pwrite_i && !serial_en_o && !sleep_o
                                |-> prdata_o == 32'h0)
      else $error("read data in power down");
endmodule
bind samc_top samc_checker u_chk (.*);

// File: sim/samc_host_model.sv
// Behavioural host processor on the far side of the mode pins.
// Assumes the testbench commands sleep, DTR, suspend and bus power.
`timescale 1ns/1ps
module samc_host_model (
   input  wire logic mclk_i,
   input  wire logic sys_rst_i,
   input  wire logic ri_i,
   input  wire logic rwake_i,
   input  wire logic go_i,
   input  wire logic pol_i,
   input  wire logic lvl_i,
   input  wire logic open_i,
   input  wire logic susp_en_i,
   input  wire logic vbus_on_i,
   output logic      dtr_o,
   output logic      dtr_drv_o,
   output logic      hss_o,
   output logic      susp_o,
   output logic      vbus_o
);
   logic asleep_r;
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i)
         asleep_r <= 1'b0;
      else if (!ri_i || rwake_i)
         asleep_r <= 1'b0;
      else if (go_i)
         asleep_r <= 1'b1;
   end
   assign hss_o     = asleep_r ~^ pol_i;
   assign susp_o    = asleep_r & susp_en_i;
   assign vbus_o    = vbus_on_i;
   assign dtr_drv_o = ~open_i;
   assign dtr_o     = open_i | lvl_i;
endmodule

// File: sim/samc_top_tb.sv
// Self-checking bench for samc_top driven over APB and the mode pins.
// Assumes the host model supplies DTR, host sense, suspend and bus power.
`timescale 1ns/1ps
module samc_top_tb;
   import samc_pkg::*;
   logic        mclk_i    = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        psel      = 1'b0;
   logic        pen       = 1'b0;
   logic        pwr       = 1'b0;
   logic [11:0] pa        = 12'h000;
   logic [31:0] pwd       = 32'h0;
   logic        apl_n     = 1'b1;
   logic        apl_drv   = 1'b0;
   logic [11:0] supply    = 12'h9a5;
   logic        h_go = 1'b0, h_pol = 1'b0, h_lvl = 1'b1, h_open = 1'b1, h_susp = 1'b0, h_vbus = 1'b1;
   logic [31:0] r;
   logic        e;
   wire         dtr, dtr_drv, hss, susp, vbus, pready, perr, ri, rw, slp, rf, card, gnss, ser, nrx;
   wire  [31:0] prd;
   wire  [7:0]  outs = {ri, rw, slp, rf, card, gnss, ser, nrx};
   int          miscompares = 0;
   int          n_checks = 0;
   int          cycles = 0;
   always #10 mclk_i = ~mclk_i;
   samc_top u_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .pready_o(pready), .pslverr_o(perr),
      .prdata_o(prd), .dtr_i(dtr), .dtr_drv_i(dtr_drv), .airplane_req_n_i(apl_n),
      .airplane_req_drv_i(apl_drv), .host_sleep_sense_i(hss), .usb_suspend_i(susp),
      .bus_power_detect_i(vbus), .baseband_supply_i(supply), .ri_o(ri), .usb_rwake_o(rw),
      .rf_en_o(rf), .card_en_o(card), .gnss_en_o(gnss), .sleep_o(slp), .serial_en_o(ser),
      .net_rx_en_o(nrx));
   samc_host_model u_host (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ri_i(ri), .rwake_i(rw),
      .go_i(h_go), .pol_i(h_pol), .lvl_i(h_lvl), .open_i(h_open), .susp_en_i(h_susp),
      .vbus_on_i(h_vbus), .dtr_o(dtr), .dtr_drv_o(dtr_drv), .hss_o(hss), .susp_o(susp),
      .vbus_o(vbus));
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         end_sim();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t register got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chko(input logic [7:0] exp, input logic [7:0] m);
      n_checks++;
      if ((outs & m) !== exp) begin
         miscompares++;
         $display("BAD %0t pins got %b exp %b", $time, outs & m, exp);
      end
   endtask
   // The bus is released for one idle cycle so no signal is assigned twice in a step.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr  <= w;
      pa   <= a;
      pwd  <= d;
      @(posedge mclk_i);
      pen <= 1'b1;
      do @(posedge mclk_i); while (pready !== 1'b1);
      r = prd;
      e = perr;
      psel <= 1'b0;
      pen  <= 1'b0;
      @(posedge mclk_i);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
      apb(1'b0, a, 32'h0);
      chk(r & m, exp);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   logic [31:0] fv[3] = '{32'h0, 32'h4, 32'h1};
   logic [31:0] fm[3] = '{32'h0, 32'h2, 32'h0};
   logic [7:0]  fo[3] = '{8'h04, 8'h0c, 8'h1c};
   initial begin
      fm[0] = 32'h1;
      cyc(5);
      sys_rst_i <= 1'b0;
      cyc(4);
      chko(8'h9f, 8'hff);
      rd(SAMC_CTRL_ADDR, 32'h0, 32'hff);
      rd(SAMC_FUN_ADDR, 32'h1, 32'hf);
      apb(1'b0, 12'h018, 32'h0);
      chk({31'h0, e}, 32'h1);
      foreach (fv[i]) begin
         apb(1'b1, SAMC_FUN_ADDR, fv[i]);
         cyc(4);
         rd(SAMC_FUN_ADDR, fv[i], 32'hf);
         rd(SAMC_STATUS_ADDR, fm[i], 32'h7);
         chko(fo[i], 8'h1c);
         apb(1'b1, SAMC_EVENT_ADDR, 32'h4);
         rd(SAMC_CMDSTAT_ADDR, fv[i] == 32'h1 ? 32'h2 : 32'h1, 32'h3);
      end
      apb(1'b1, SAMC_FUN_ADDR, 32'h2);
      rd(SAMC_FUN_ADDR, 32'h9, 32'hf);
      apl_n   <= 1'b0;
      apl_drv <= 1'b1;
      cyc(6);
      chko(8'h10, 8'h10);
      apb(1'b1, SAMC_CTRL_ADDR, 32'h2);
      cyc(6);
      chko(8'h00, 8'h10);
      apl_n   <= 1'b1;
      apl_drv <= 1'b0;
      cyc(6);
      chko(8'h10, 8'h10);
      h_open <= 1'b0;
      h_lvl  <= 1'b0;
      apb(1'b1, SAMC_CTRL_ADDR, 32'h1);
      cyc(8);
      chko(8'h00, 8'h20);
      h_lvl <= 1'b1;
      cyc(8);
      chko(8'h31, 8'h31);
      rd(SAMC_STATUS_ADDR, 32'h3, 32'h7);
      h_lvl <= 1'b0;
      cyc(8);
      chko(8'h00, 8'h20);
      apb(1'b1, SAMC_FUN_ADDR, 32'h0);
      h_lvl <= 1'b1;
      cyc(8);
      chko(8'h20, 8'h38);
      h_lvl <= 1'b0;
      cyc(8);
      chko(8'h00, 8'h38);
      rd(SAMC_STATUS_ADDR, 32'h1, 32'h7);
      apb(1'b1, SAMC_FUN_ADDR, 32'h1);
      for (int p = 1; p >= 0; p--) begin
         apb(1'b1, SAMC_CTRL_ADDR, 32'(p) << 2);
         h_pol <= p[0];
         h_go  <= 1'b1;
         @(posedge mclk_i);
         h_go <= 1'b0;
         cyc(6);
         rd(SAMC_STATUS_ADDR, 32'h10, 32'h10);
      end
      apb(1'b1, SAMC_EVENT_ADDR, 32'h1);
      cyc(4);
      chko(8'h00, 8'hc0);
      cyc(RI_PULSE_CYC + 10);
      chko(8'h80, 8'hc0);
      rd(SAMC_STATUS_ADDR, 32'h0, 32'h10);
      h_open <= 1'b1;
      h_susp <= 1'b1;
      apb(1'b1, SAMC_CTRL_ADDR, 32'h29);
      h_go <= 1'b1;
      @(posedge mclk_i);
      h_go <= 1'b0;
      cyc(8);
      chko(8'h20, 8'h20);
      apb(1'b1, SAMC_EVENT_ADDR, 32'h1);
      cyc(4);
      chko(8'hc0, 8'hc0);
      cyc(RWAKE_PULSE_CYC + 10);
      apb(1'b1, SAMC_EVENT_ADDR, 32'h2);
      cyc(6);
      chko(8'h00, 8'h20);
      h_susp <= 1'b0;
      apb(1'b1, SAMC_CTRL_ADDR, 32'h19);
      cyc(8);
      chko(8'h00, 8'h20);
      h_vbus <= 1'b0;
      cyc(8);
      chko(8'h20, 8'h20);
      h_vbus <= 1'b1;
      cyc(8);
      chko(8'h00, 8'h20);
      apb(1'b1, SAMC_EVENT_ADDR, 32'h8);
      cyc(2);
      rd(SAMC_SUPPLY_ADDR, 32'h9a5, 32'hfff);
      apb(1'b1, SAMC_CTRL_ADDR, 32'h40);
      cyc(6);
      chko(8'h00, 8'h02);
      apb(1'b1, SAMC_FUN_ADDR, 32'h4);
      rd(SAMC_FUN_ADDR, 32'h0, 32'hffffffff);
      end_sim();
   end
endmodule

// File: verilog/samc_apb_slave.sv
// APB slave front end: zero wait states, combinational read data, error on unmapped address.
// Assumes the core returns read data combinationally from the address.
`timescale 1ns/1ps
module samc_apb_slave
   import samc_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic [31:0]      prdata_o,
   samc_bus_if.slave        bus
);
   wire access_w = psel_i & penable_i;
   wire mapped_w = (paddr_i[11:2] <= SAMC_CMDSTAT_ADDR[11:2]) && (paddr_i[1:0] == 2'h0);

   assign pready_o  = 1'b1;
   assign pslverr_o = access_w & ~mapped_w;
   assign bus.wr_stb = access_w & pwrite_i & mapped_w;
   assign bus.addr   = paddr_i;
   assign bus.wdata  = pwdata_i;
   assign prdata_o   = mapped_w ? bus.rdata : 32'h0000_0000;
endmodule

// File: verilog/samc_bus_if.sv
// Interface carrying one write strobe with address and write data from the APB slave to the mode core, and read data back.
// Assumes one clock domain; the APB slave drives strobe, address and write data, the core drives read data.
`timescale 1ns/1ps
interface samc_bus_if;
   logic        wr_stb;
   logic [11:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   modport slave (output wr_stb, output addr, output wdata, input rdata);
   modport core  (input wr_stb, input addr, input wdata, output rdata);
endinterface

// File: verilog/samc_pkg.sv
// Package for the sleep and airplane mode controller: register map, field values, reset values, timing.
// Assumes a 50 MHz system clock and a 32-bit APB slave port.
package samc_pkg;
   localparam logic [11:0] SAMC_CTRL_ADDR    = 12'h000;
   localparam logic [11:0] SAMC_FUN_ADDR     = 12'h004;
   localparam logic [11:0] SAMC_STATUS_ADDR  = 12'h008;
   localparam logic [11:0] SAMC_EVENT_ADDR   = 12'h00c;
   localparam logic [11:0] SAMC_SUPPLY_ADDR  = 12'h010;
   localparam logic [11:0] SAMC_CMDSTAT_ADDR = 12'h014;

   // Control register bit positions.
   localparam int CTRL_SLEEP_EN   = 0;
   localparam int CTRL_APLANE_EN  = 1;
   localparam int CTRL_HSS_POL    = 2;
   localparam int CTRL_SCEN_LSB   = 3;
   localparam int CTRL_RWAKE_EN   = 5;
   localparam int CTRL_PDOWN      = 6;
   // Event register bit positions (write 1 to request).
   localparam int EVT_REPORT      = 0;
   localparam int EVT_USB_DATA    = 1;
   localparam int EVT_RF_CMD      = 2;
   localparam int EVT_VBAT_QUERY  = 3;

   localparam logic [6:0] CTRL_RESET = 7'h00;

   typedef enum logic [1:0] {
      SAMC_SCEN_UART = 2'h0,
      SAMC_SCEN_USB_RWAKE = 2'h1,
      SAMC_SCEN_USB_RI = 2'h2,
      SAMC_SCEN_USB_NOSUSP = 2'h3
   } samc_scen_e;

   localparam logic [2:0] FUN_MIN      = 3'h0;
   localparam logic [2:0] FUN_FULL     = 3'h1;
   localparam logic [2:0] FUN_AIRPLANE = 3'h4;

   typedef enum logic [2:0] {
      SAMC_M_FULL,
      SAMC_M_MIN,
      SAMC_M_AIRPLANE,
      SAMC_M_SLEEP,
      SAMC_M_PDOWN
   } samc_mode_e;

   // Ring indicator pulse width and remote wakeup pulse width.
   localparam int RI_PULSE_NS     = 120000;
   localparam int RI_PULSE_CYC    = RI_PULSE_NS / 20;
   localparam int RWAKE_PULSE_NS  = 2000;
   localparam int RWAKE_PULSE_CYC = RWAKE_PULSE_NS / 20;
endpackage

// File: verilog/samc_top.sv
// Sleep, airplane and functionality-level controller of a cellular module, with APB registers.
// Assumes pin inputs are asynchronous and APB is on mclk_i.
`timescale 1ns/1ps
// Summary of operation
// - UART sleep needs enable and DTR high
// - UART sleep wakes on DTR low
// - Pending report pulses ring indicator to host
// - Host sleep sensed with selectable polarity
// - USB sleep needs enable, DTR high, suspend
// - USB data wakes module from sleep
// - Pending report signals USB remote wakeup
// - VBUS restored wakes module
// - Airplane pin low enters airplane when enabled
// - Airplane pin control disabled after reset
// - Function level accepts only 0, 1, 4
// - Minimum mode disables card and RF
// - Airplane disables RF, rejects RF commands
// - Function level leaves positioning untouched
// - Power-down stops software and serial responses
// - Sleep keeps network reception alive unless taken in minimum or airplane level
// - Battery query reports baseband supply voltage
// - DTR pulled up, open counts high
module samc_top
   import samc_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic [31:0]      prdata_o,
   input  wire logic        dtr_i,
   input  wire logic        dtr_drv_i,
   input  wire logic        airplane_req_n_i,
   input  wire logic        airplane_req_drv_i,
   input  wire logic        host_sleep_sense_i,
   input  wire logic        usb_suspend_i,
   input  wire logic        bus_power_detect_i,
   input  wire logic [11:0] baseband_supply_i,
   output logic             ri_o,
   output logic             usb_rwake_o,
   output logic             rf_en_o,
   output logic             card_en_o,
   output logic             gnss_en_o,
   output logic             sleep_o,
   output logic             serial_en_o,
   output logic             net_rx_en_o
);
   samc_bus_if bus ();

   samc_apb_slave u_apb (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .psel_i    (psel_i),
      .penable_i (penable_i),
      .pwrite_i  (pwrite_i),
      .paddr_i   (paddr_i),
      .pwdata_i  (pwdata_i),
      .pready_o  (pready_o),
      .pslverr_o (pslverr_o),
      .prdata_o  (prdata_o),
      .bus       (bus)
   );

   // Two-flop synchronisers for all pin levels; the pad pull-ups are modelled by the drive flags.
   // Reset values sit at the idle levels of DTR, airplane and bus power, with suspend high and host sense low;
   // sleep is disabled after reset, so the two cycles after reset show no false wake and no false sleep entry.
   logic [4:0] sync1_r;
   logic [4:0] sync2_r;
   wire  [4:0] pins_w;
   // An undriven DTR or airplane pin reads high, as the pad pull-up would make it.
   assign pins_w = {bus_power_detect_i, usb_suspend_i, host_sleep_sense_i,
                    airplane_req_n_i | ~airplane_req_drv_i, dtr_i | ~dtr_drv_i};
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sync1_r <= 5'h1b;
         sync2_r <= 5'h1b;
      end else begin
         sync1_r <= pins_w;
         sync2_r <= sync1_r;
      end
   end
   wire dtr_w     = sync2_r[0];
   wire aplane_n_w = sync2_r[1];
   wire hss_w     = sync2_r[2];
   wire susp_w    = sync2_r[3];
   wire vbus_w    = sync2_r[4];

   // Registers.
   logic [6:0]  ctrl_r;
   logic [2:0]  fun_r;
   logic        fun_err_r;
   logic        rf_rej_r;
   logic        rf_acc_r;
   logic [11:0] supply_r;
   logic        report_pend_r;
   logic        usb_data_r;
   samc_mode_e  mode_r;
   samc_mode_e  mode_nxt;

   wire wr_ctrl = bus.wr_stb && bus.addr == SAMC_CTRL_ADDR;
   wire wr_fun  = bus.wr_stb && bus.addr == SAMC_FUN_ADDR;
   wire wr_evt  = bus.wr_stb && bus.addr == SAMC_EVENT_ADDR;
   wire fun_ok  = bus.wdata[2:0] == FUN_MIN || bus.wdata[2:0] == FUN_FULL
                  || bus.wdata[2:0] == FUN_AIRPLANE;
   wire fun_legal = fun_ok && bus.wdata[31:3] == 29'h0;
   wire pdown_w = mode_r == SAMC_M_PDOWN;

   wire        sleep_en_w = ctrl_r[CTRL_SLEEP_EN];
   wire        aplane_en_w = ctrl_r[CTRL_APLANE_EN];
   samc_scen_e scen_w;
   assign scen_w = samc_scen_e'(ctrl_r[CTRL_SCEN_LSB +: 2]);
   // Host asleep when the sense pin matches the configured active level.
   wire host_asleep_w = hss_w == ctrl_r[CTRL_HSS_POL];

   wire aplane_pin_w = aplane_en_w & ~aplane_n_w;
   wire in_airplane_w = fun_r == FUN_AIRPLANE || aplane_pin_w;

   // Sleep entry and wake conditions per scenario.
   wire uart_w   = scen_w == SAMC_SCEN_UART;
   wire nosusp_w = scen_w == SAMC_SCEN_USB_NOSUSP;
   wire enter_w  = sleep_en_w & dtr_w & (uart_w
                   | (nosusp_w & ~vbus_w)
                   | (~uart_w & ~nosusp_w & susp_w));
   wire wake_w   = (uart_w & ~dtr_w)
                   | (nosusp_w & vbus_w)
                   | (~uart_w & ~nosusp_w & usb_data_r)
                   | ~sleep_en_w;

   // Level the controller settles in outside sleep and power-down. Waking goes straight to it, so
   // a sleep taken in minimum or airplane level never lets RF on for a cycle on the way out.
   samc_mode_e level_w;
   assign level_w = (fun_r == FUN_MIN) ? SAMC_M_MIN
                    : (in_airplane_w ? SAMC_M_AIRPLANE : SAMC_M_FULL);

   // Single mode register; all pin outputs except ri_o and usb_rwake_o derive from it in one edge.
   // Limitation: a power-down request made while asleep takes effect after the next wake.
   always_comb begin
      mode_nxt = mode_r;
      unique case (mode_r)
         SAMC_M_PDOWN: mode_nxt = SAMC_M_PDOWN;
         SAMC_M_SLEEP: begin
            if (wake_w) begin
               mode_nxt = level_w;
            end
         end
         default: begin
            if (ctrl_r[CTRL_PDOWN]) begin
               mode_nxt = SAMC_M_PDOWN;
            end else if (enter_w) begin
               mode_nxt = SAMC_M_SLEEP;
            end else if (fun_r == FUN_MIN) begin
               mode_nxt = SAMC_M_MIN;
            end else if (in_airplane_w) begin
               mode_nxt = SAMC_M_AIRPLANE;
            end else begin
               mode_nxt = SAMC_M_FULL;
            end
         end
      endcase
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mode_r <= SAMC_M_FULL;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   // Power-down only leaves through system reset, so software writes are ignored there.
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl_r    <= CTRL_RESET;
         fun_r     <= FUN_FULL;
         fun_err_r <= 1'b0;
      end else if (!pdown_w) begin
         if (wr_ctrl) begin
            ctrl_r <= bus.wdata[6:0];
         end
         if (wr_fun) begin
            if (fun_legal) begin
               fun_r <= bus.wdata[2:0];
            end
            fun_err_r <= ~fun_legal;
         end
      end
   end

   // Command events: RF commands, battery query, report and USB traffic.
   wire evt_rf   = wr_evt & bus.wdata[EVT_RF_CMD] & ~pdown_w;
   wire evt_vbat = wr_evt & bus.wdata[EVT_VBAT_QUERY] & ~pdown_w;
   wire rf_block = in_airplane_w || fun_r == FUN_MIN;
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rf_rej_r <= 1'b0;
         rf_acc_r <= 1'b0;
         supply_r <= 12'h000;
      end else begin
         if (evt_rf) begin
            rf_rej_r <= rf_block;
            rf_acc_r <= ~rf_block;
         end
         if (evt_vbat) begin
            supply_r <= baseband_supply_i;
         end
      end
   end

   // Report pending flag: set wins over clear on the same edge.
   // A report raised while the host is awake goes out over the link as usual,
   // so the flag clears without a wake pulse.
   logic [12:0] pulse_cnt_r;
   wire pulse_done_w = pulse_cnt_r == 13'h0001;
   wire use_rwake_w  = scen_w == SAMC_SCEN_USB_RWAKE && ctrl_r[CTRL_RWAKE_EN];
   wire start_w      = report_pend_r && host_asleep_w && pulse_cnt_r == 13'h0000 && !pdown_w;
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         report_pend_r <= 1'b0;
         usb_data_r    <= 1'b0;
      end else begin
         if (wr_evt && bus.wdata[EVT_REPORT]) begin
            report_pend_r <= 1'b1;
         end else if (start_w || (report_pend_r && !host_asleep_w)) begin
            report_pend_r <= 1'b0;
         end
         if (wr_evt && bus.wdata[EVT_USB_DATA]) begin
            usb_data_r <= 1'b1;
         end else if (mode_r != SAMC_M_SLEEP) begin
            usb_data_r <= 1'b0;
         end
      end
   end

   // Wake pulse to the host: ring indicator, or remote wakeup when supported.
   // Only one pulse runs at a time; a report raised during a pulse waits until
   // the counter is back at zero, which keeps the two wake signals exclusive.
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pulse_cnt_r <= 13'h0000;
         ri_o        <= 1'b1;
         usb_rwake_o <= 1'b0;
      end else if (start_w) begin
         pulse_cnt_r <= use_rwake_w ? 13'(RWAKE_PULSE_CYC) : 13'(RI_PULSE_CYC);
         ri_o        <= use_rwake_w;
         usb_rwake_o <= use_rwake_w;
      end else if (pulse_cnt_r != 13'h0000) begin
         pulse_cnt_r <= pulse_cnt_r - 13'h0001;
         if (pulse_done_w) begin
            ri_o        <= 1'b1;
            usb_rwake_o <= 1'b0;
         end
      end
   end

   // Outputs follow the mode register. Positioning stays on in every level.
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rf_en_o     <= 1'b0;
         card_en_o   <= 1'b0;
         gnss_en_o   <= 1'b0;
         sleep_o     <= 1'b0;
         serial_en_o <= 1'b0;
         net_rx_en_o <= 1'b0;
      end else begin
         rf_en_o     <= mode_nxt == SAMC_M_FULL
                        || (mode_nxt == SAMC_M_SLEEP && !rf_block);
         card_en_o   <= mode_nxt != SAMC_M_MIN && mode_nxt != SAMC_M_PDOWN
                        && fun_r != FUN_MIN;
         gnss_en_o   <= mode_nxt != SAMC_M_PDOWN;
         sleep_o     <= mode_nxt == SAMC_M_SLEEP;
         serial_en_o <= mode_nxt != SAMC_M_PDOWN;
         net_rx_en_o <= mode_nxt == SAMC_M_FULL
                        || (mode_nxt == SAMC_M_SLEEP && !rf_block);
      end
   end

   // Read mux; in power-down the slave still answers but returns zeros.
   logic [31:0] rd_w;
   always_comb begin
      rd_w = 32'h0000_0000;
      if (!pdown_w) begin
         unique case (bus.addr)
            SAMC_CTRL_ADDR:    rd_w = {25'h0, ctrl_r};
            SAMC_FUN_ADDR:     rd_w = {28'h0, fun_err_r, fun_r};
            SAMC_STATUS_ADDR:  rd_w = {22'h0, vbus_w, susp_w, hss_w, aplane_n_w, dtr_w,
                                       host_asleep_w, 1'b0, mode_r};
            SAMC_SUPPLY_ADDR:  rd_w = {20'h0, supply_r};
            SAMC_CMDSTAT_ADDR: rd_w = {29'h0, report_pend_r, rf_acc_r, rf_rej_r};
            default:           rd_w = 32'h0000_0000;
         endcase
      end
   end
   assign bus.rdata = rd_w;
endmodule
